//--- inc/pds_pkg.sv
/*
 * pds_pkg: constants, codes and carrier structs of the program download sequencer.
 * assumes: one 100 MHz clock; a frame layer below does bytes and check codes.
 */
package pds_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000; // mclk rate
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000; // cycles in one millisecond
	localparam int unsigned TRANS_WAIT_MS = 500; // least transition wait
	localparam int unsigned TRANS_WAIT_CYC = TRANS_WAIT_MS * CYC_PER_MS; // least time, exact
	localparam int unsigned RSP_TIMEOUT_MS = 300; // response_timeout
	localparam int unsigned RSP_TIMEOUT_CYC = RSP_TIMEOUT_MS * CYC_PER_MS; // longest, exact

	// ---------------------------------------------------------------
	// command numbers and field values
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_DL_REQ = 8'h00; // download request command_number
	localparam logic [7:0] CMD_DL_DONE = 8'h01; // completion notification command_number
	localparam logic [15:0] DONE_DATA_LEN = 16'h0001; // completion data_length
	localparam logic [7:0] RESULT_FAIL = 8'h00; // completion result: failure
	localparam logic [7:0] RESULT_OK = 8'h01; // completion result: success
	localparam logic [7:0] ENV_INTERP = 8'h00; // interpreter environment identifier
	localparam logic [7:0] FN_NONE = 8'h00; // frame_number that is never checked
	localparam logic [7:0] FN_FIRST = 8'h01; // first frame_number issued
	localparam logic [15:0] SEQ_INFO = 16'h0000; // sequence asking for software info
	localparam logic [15:0] SEQ_ENV = 16'h0001; // sequence carrying environment byte
	localparam logic [15:0] SEQ_BODY = 16'h0002; // first sequence past the environment
	localparam logic [15:0] SEQ_HDR_BYTES = 16'h0002; // split sequence field ahead of data
	localparam logic [1:0] RETRY_LIMIT = 2'h3; // retransmissions before giving up
	localparam logic [23:0] MAX_PROG_BYTES = 24'h008000; // largest download accepted

	// ---------------------------------------------------------------
	// fifo shape
	// ---------------------------------------------------------------
	localparam int unsigned PROG_FIFO_WIDTH = 8; // one program byte per word
	localparam int unsigned PROG_FIFO_DEPTH = 8; // words buffered toward the store

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PDS_TX_REQ = 2'h0, // download request
		PDS_TX_VALIDATE = 2'h1, // validation notice: current speed only
		PDS_TX_DONE = 2'h2 // completion notification
	} pds_tx_kind_e;

	// frame to be built and sent by the frame layer
	typedef struct packed {
		pds_tx_kind_e kind; // which frame
		logic [7:0] command_number; // command field
		logic [7:0] frame_number; // frame number to carry
		logic [15:0] data_length; // data_length for a completion
		logic [15:0] seq; // first_payload_field of a request
		logic [7:0] result; // result byte of a completion
		logic speed_current; // send at current speed instead of detected
	} pds_tx_s;

	// response header decoded by the frame layer after its check code
	typedef struct packed {
		logic fcc_ok; // frame_check_code was good
		logic [7:0] frame_number; // frame number received
		logic [23:0] maker; // maker code in the response
		logic [15:0] data_length; // data_length received
		logic [71:0] sw_info; // software information (sequence 0)
		logic [15:0] split_count; // number of split messages (sequence 0)
	} pds_rsp_s;

endpackage

//--- src/pds_fifo.sv
/*
 * pds_fifo: small synchronous fifo with valid/ready on both sides.
 * assumes: one clock, asynchronous active-high reset, depth a power of two.
 */
`timescale 1ns/1ps
module pds_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// flush drops everything held
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH]; // storage words
	logic [AW-1:0] wr_ptr_ff; // next write slot
	logic [AW-1:0] rd_ptr_ff; // next read slot
	logic [AW:0] count_ff; // words held
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// full and empty straight from the count
	assign in_ready = (count_ff != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];

	// storage has no reset: contents are only read behind count
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + AW'(push);
			rd_ptr_ff <= rd_ptr_ff + AW'(pop);
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- src/pds_sequencer.sv
/*
 * pds_sequencer: adapter-side program download sequencer.
 * assumes: a frame layer sends frames and checks answers; a store drains prog_*.
 */
`timescale 1ns/1ps
module pds_sequencer #(
	parameter int unsigned TRANS_WAIT_CYC = pds_pkg::TRANS_WAIT_CYC,
	parameter int unsigned RSP_TIMEOUT_CYC = pds_pkg::RSP_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// results of the interface recognition exchange
	input wire logic start, // one-cycle pulse: begin a download
	input wire logic peer_to_peer, // b0 of the recognition response
	input wire logic data_retained, // b3 of the recognition response
	input wire logic speed_usable, // requested speed can be used
	input wire logic [71:0] stored_sw_info, // software info already held
	input wire logic [7:0] own_env_id, // environment built into this adapter
	// frames to send
	output logic tx_valid,
	input wire logic tx_ready,
	output pds_pkg::pds_tx_s tx_frame,
	// response headers
	input wire logic rsp_valid,
	input wire pds_pkg::pds_rsp_s rsp_hdr,
	// response data bytes
	input wire logic pay_valid,
	output logic pay_ready,
	input wire logic [7:0] pay_data,
	input wire logic pay_last,
	// program body toward the store
	output logic prog_valid,
	input wire logic prog_ready,
	output logic [7:0] prog_data,
	output logic prog_discard, // one-cycle pulse: drop body received so far
	// status
	output logic busy, // sequence running
	output logic done_ok, // last download finished well
	output logic error_led // download error shown
);
	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01, // waiting for start
		ST_TRANS = 8'h02, // transition wait
		ST_VALID = 8'h04, // sending validation notice
		ST_REQ = 8'h08, // sending a request
		ST_WAIT = 8'h10, // awaiting a response header
		ST_PAY = 8'h20, // taking data bytes
		ST_DONE = 8'h40, // sending completion
		ST_DRAIN = 8'h80 // swallowing bytes of a rejected frame
	} pds_state_e;

	pds_state_e state_ff, nxt_state;
	logic [31:0] tmr_ff, nxt_tmr; // wait timer
	logic [1:0] retry_ff, nxt_retry; // retransmissions made
	logic [7:0] fn_ff, nxt_fn; // frame number of pending request
	logic [15:0] seq_ff, nxt_seq; // sequence of pending request
	logic [15:0] split_ff, nxt_split; // split messages announced
	logic sw_same_ff, nxt_sw_same; // software already held
	logic first_ff, nxt_first; // next byte is the environment byte
	logic [23:0] total_ff, nxt_total; // body bytes taken
	logic [15:0] left_ff, nxt_left; // data bytes left in this frame
	logic cur_speed_ff, nxt_cur_speed; // download at current speed
	logic result_ff, nxt_result; // result to report
	logic err_ff, nxt_err; // error indicator
	logic ok_ff, nxt_ok; // success indicator
	logic discard_ff, nxt_discard; // discard pulse
	logic [23:0] maker_ff; // maker code requested

	// ---------------------------------------------------------------
	// decode of the response
	// ---------------------------------------------------------------
	wire fn_bad = (rsp_hdr.frame_number != pds_pkg::FN_NONE) &&
		(rsp_hdr.frame_number != fn_ff);
	wire rsp_fail = !rsp_hdr.fcc_ok || fn_bad;
	wire maker_bad = (rsp_hdr.maker != maker_ff);
	wire tmr_out = (tmr_ff >= RSP_TIMEOUT_CYC - 1);
	wire trans_over = (tmr_ff >= TRANS_WAIT_CYC - 1);
	wire retry_spent = (retry_ff == pds_pkg::RETRY_LIMIT);
	wire need_wait = peer_to_peer && data_retained;
	wire [15:0] body_len = rsp_hdr.data_length - pds_pkg::SEQ_HDR_BYTES;
	wire sw_match = (rsp_hdr.sw_info == stored_sw_info);
	// only the interpreter code names an environment; others never match
	wire env_known = (own_env_id == pds_pkg::ENV_INTERP);
	wire env_ok = env_known && (pay_data == own_env_id);
	wire body_byte = !first_ff;
	wire over_size = (total_ff >= pds_pkg::MAX_PROG_BYTES);
	wire last_split = (seq_ff >= split_ff);
	wire fifo_in_ready;
	wire pay_take = pay_valid && pay_ready;
	wire [7:0] next_fn = (fn_ff == 8'hFF) ? pds_pkg::FN_FIRST : fn_ff + 8'h01;

	// the environment byte is not stored; body bytes need room in the fifo
	assign pay_ready = (state_ff == ST_DRAIN) ||
		((state_ff == ST_PAY) && (first_ff || fifo_in_ready));

	// ---------------------------------------------------------------
	// outgoing frame
	// ---------------------------------------------------------------
	assign tx_valid = (state_ff == ST_VALID) || (state_ff == ST_REQ) || (state_ff == ST_DONE);

	always_comb begin
		tx_frame = '0;
		tx_frame.frame_number = fn_ff;
		tx_frame.speed_current = cur_speed_ff;
		unique case (state_ff)
			ST_VALID: begin
				tx_frame.kind = pds_pkg::PDS_TX_VALIDATE;
			end
			ST_DONE: begin
				tx_frame.kind = pds_pkg::PDS_TX_DONE;
				tx_frame.command_number = pds_pkg::CMD_DL_DONE;
				tx_frame.data_length = pds_pkg::DONE_DATA_LEN;
				tx_frame.result = result_ff ? pds_pkg::RESULT_OK : pds_pkg::RESULT_FAIL;
			end
			default: begin
				tx_frame.kind = pds_pkg::PDS_TX_REQ;
				tx_frame.command_number = pds_pkg::CMD_DL_REQ;
				tx_frame.seq = seq_ff;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// sequence control
	// ---------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_ff;
		nxt_retry = retry_ff;
		nxt_fn = fn_ff;
		nxt_seq = seq_ff;
		nxt_split = split_ff;
		nxt_sw_same = sw_same_ff;
		nxt_first = first_ff;
		nxt_total = total_ff;
		nxt_left = left_ff;
		nxt_cur_speed = cur_speed_ff;
		nxt_result = result_ff;
		nxt_err = err_ff;
		nxt_ok = ok_ff;
		nxt_discard = 1'b0;
		unique case (state_ff)
			ST_IDLE: begin
				if (start) begin
					nxt_err = 1'b0;
					nxt_ok = 1'b0;
					nxt_tmr = '0;
					nxt_retry = '0;
					nxt_seq = pds_pkg::SEQ_INFO;
					nxt_fn = pds_pkg::FN_FIRST;
					nxt_total = '0;
					nxt_cur_speed = !speed_usable;
					// the peer changes method first when it keeps the data
					if (need_wait) begin
						nxt_state = ST_TRANS;
					end else if (!speed_usable) begin
						nxt_state = ST_VALID;
					end else begin
						nxt_state = ST_REQ;
					end
				end
			end
			ST_TRANS: begin
				nxt_tmr = tmr_ff + 32'h1;
				if (trans_over) begin
					nxt_state = speed_usable ? ST_REQ : ST_VALID;
				end
			end
			ST_VALID: begin
				if (tx_ready) begin
					nxt_state = ST_REQ;
				end
			end
			ST_REQ: begin
				if (tx_ready) begin
					nxt_tmr = '0;
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				nxt_tmr = tmr_ff + 32'h1;
				if (rsp_valid && rsp_fail || !rsp_valid && tmr_out) begin
					// same frame number again so a late answer still matches
					if (retry_spent) begin
						nxt_result = 1'b0;
						nxt_err = 1'b1;
						nxt_discard = 1'b1;
						nxt_state = ST_DONE;
					end else begin
						nxt_retry = retry_ff + 2'h1;
						nxt_state = ST_REQ;
					end
					if (rsp_valid && body_len != '0 && seq_ff != pds_pkg::SEQ_INFO) begin
						nxt_left = body_len;
						nxt_state = ST_DRAIN;
					end
				end else if (rsp_valid && maker_bad) begin
					nxt_result = 1'b0;
					nxt_err = 1'b1;
					nxt_discard = 1'b1;
					nxt_left = body_len;
					nxt_state = (seq_ff != pds_pkg::SEQ_INFO && body_len != '0) ? ST_DRAIN : ST_DONE;
				end else if (rsp_valid) begin
					nxt_retry = '0;
					nxt_fn = next_fn;
					if (seq_ff == pds_pkg::SEQ_INFO) begin
						nxt_sw_same = sw_match;
						nxt_split = rsp_hdr.split_count;
						nxt_seq = pds_pkg::SEQ_ENV;
						nxt_state = ST_REQ;
					end else begin
						nxt_first = (seq_ff == pds_pkg::SEQ_ENV);
						nxt_left = body_len;
						nxt_state = ST_PAY;
					end
				end
			end
			ST_PAY: begin
				if (pay_take) begin
					nxt_left = left_ff - 16'h1;
					nxt_first = 1'b0;
					if (first_ff && !env_ok) begin
						nxt_result = 1'b0;
						nxt_err = 1'b1;
						nxt_discard = 1'b1;
						nxt_state = pay_last ? ST_DONE : ST_DRAIN;
					end else if (body_byte && over_size) begin
						nxt_result = 1'b0;
						nxt_err = 1'b1;
						nxt_discard = 1'b1;
						nxt_state = pay_last ? ST_DONE : ST_DRAIN;
					end else if (pay_last) begin
						nxt_total = total_ff + 24'(body_byte);
						if (seq_ff == pds_pkg::SEQ_ENV && sw_same_ff) begin
							nxt_result = 1'b1;
							nxt_state = ST_DONE;
						end else if (last_split) begin
							nxt_result = 1'b1;
							nxt_state = ST_DONE;
						end else begin
							nxt_seq = seq_ff + 16'h1;
							nxt_state = ST_REQ;
						end
					end else begin
						nxt_total = total_ff + 24'(body_byte);
					end
				end
			end
			ST_DRAIN: begin
				// rejected data is swallowed so the link stays aligned
				if (pay_take && pay_last) begin
					nxt_state = (err_ff || retry_spent && !result_ff) ? ST_DONE : ST_REQ;
				end
			end
			ST_DONE: begin
				if (tx_ready) begin
					nxt_ok = result_ff;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			tmr_ff <= '0;
			retry_ff <= '0;
			fn_ff <= pds_pkg::FN_FIRST;
			seq_ff <= '0;
			split_ff <= '0;
			sw_same_ff <= 1'b0;
			first_ff <= 1'b0;
			total_ff <= '0;
			left_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			retry_ff <= nxt_retry;
			fn_ff <= nxt_fn;
			seq_ff <= nxt_seq;
			split_ff <= nxt_split;
			sw_same_ff <= nxt_sw_same;
			first_ff <= nxt_first;
			total_ff <= nxt_total;
			left_ff <= nxt_left;
		end
	end

	// status and flags
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cur_speed_ff <= 1'b0;
			result_ff <= 1'b0;
			err_ff <= 1'b0;
			ok_ff <= 1'b0;
			discard_ff <= 1'b0;
		end else begin
			cur_speed_ff <= nxt_cur_speed;
			result_ff <= nxt_result;
			err_ff <= nxt_err;
			ok_ff <= nxt_ok;
			discard_ff <= nxt_discard;
		end
	end

	// maker code captured from the stored info at start
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			maker_ff <= '0;
		end else if (state_ff == ST_IDLE && start) begin
			maker_ff <= stored_sw_info[71:48];
		end
	end

	// ---------------------------------------------------------------
	// program body buffer
	// ---------------------------------------------------------------
	// body bytes only; the environment byte is checked and dropped
	pds_fifo #(
		.WIDTH(pds_pkg::PROG_FIFO_WIDTH),
		.DEPTH(pds_pkg::PROG_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.flush(discard_ff),
		.in_valid(pay_valid && state_ff == ST_PAY && body_byte && !over_size),
		.in_ready(fifo_in_ready),
		.in_data(pay_data),
		.out_valid(prog_valid),
		.out_ready(prog_ready),
		.out_data(prog_data)
	);

	assign prog_discard = discard_ff;
	assign busy = (state_ff != ST_IDLE);
	assign done_ok = ok_ff;
	assign error_led = err_ff;
endmodule

//--- test/pds_properties.sv
/* pds_properties: port timing and frame field checks.
   assumes: bound to pds_sequencer, one clock, async reset. */
`timescale 1ns/1ps
module pds_checker #(
	parameter int unsigned TRANS_WAIT_CYC = 50,
	parameter int unsigned RSP_TIMEOUT_CYC = 40
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// control inputs
	input wire logic start,
	input wire logic peer_to_peer,
	input wire logic data_retained,
	input wire logic speed_usable,
	// frames and answers
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire pds_pkg::pds_tx_s tx_frame,
	input wire logic rsp_valid,
	// status
	input wire logic busy,
	input wire logic error_led
);
	// ------------------------------
	// helper state
	// ------------------------------
	wire logic take = tx_valid && tx_ready; // frame handed over
	wire logic is_req = tx_frame.kind == pds_pkg::PDS_TX_REQ; // request frame
	wire logic is_done = tx_frame.kind == pds_pkg::PDS_TX_DONE; // completion frame
	wire logic go = start && !busy; // start accepted
	logic wait_ff; // request out, answer pending
	logic arm_ff; // transition wait pending
	logic [31:0] cnt_ff; // cycles since start or last frame
	logic [7:0] fn_ff; // frame number of last request
	// count restarts at each hand-over: resends timed from the last
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wait_ff <= 1'b0;
			arm_ff <= 1'b0;
			cnt_ff <= 32'h0;
			fn_ff <= 8'h00;
		end else begin
			wait_ff <= take ? is_req : (rsp_valid ? 1'b0 : wait_ff);
			arm_ff <= go ? (peer_to_peer && data_retained) : (take ? 1'b0 : arm_ff);
			cnt_ff <= (go || take) ? 32'h0 : cnt_ff + 32'h1;
			fn_ff <= (take && is_req) ? tx_frame.frame_number : fn_ff;
		end
	end
	// ------------------------------
	// properties
	// ------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	property p_done_fmt;
		tx_valid && is_done |-> tx_frame.command_number == pds_pkg::CMD_DL_DONE
			&& tx_frame.data_length == pds_pkg::DONE_DATA_LEN;
	endproperty
	a_done_fmt: assert property (p_done_fmt) else $error("bad completion fields");
	property p_speed;
		tx_valid && is_req |-> tx_frame.speed_current == !speed_usable;
	endproperty
	a_speed: assert property (p_speed) else $error("request at wrong speed");
	property p_validate;
		go && !speed_usable && !(peer_to_peer && data_retained) |=> tx_valid
			&& tx_frame.kind == pds_pkg::PDS_TX_VALIDATE;
	endproperty
	a_validate: assert property (p_validate) else $error("no validation notice");
	property p_trans;
		tx_valid && arm_ff |-> cnt_ff >= TRANS_WAIT_CYC - 1;
	endproperty
	a_trans: assert property (p_trans) else $error("transition wait too short");
	property p_retry;
		take && is_req && wait_ff |-> cnt_ff >= RSP_TIMEOUT_CYC - 1
			&& tx_frame.frame_number == fn_ff;
	endproperty
	a_retry: assert property (p_retry) else $error("early or renumbered resend");
	property p_wait_max;
		wait_ff |-> cnt_ff <= RSP_TIMEOUT_CYC + 2;
	endproperty
	a_wait_max: assert property (p_wait_max) else $error("answer awaited too long");
	property p_ok_clean;
		tx_valid && is_done && tx_frame.result == pds_pkg::RESULT_OK |-> !error_led;
	endproperty
	a_ok_clean: assert property (p_ok_clean) else $error("error shown on success");
	property p_fail_led;
		take && is_done && tx_frame.result == pds_pkg::RESULT_FAIL |-> ##[0:2] error_led;
	endproperty
	a_fail_led: assert property (p_fail_led) else $error("failure not shown");
	c_ok: cover property (take && is_done && tx_frame.result == pds_pkg::RESULT_OK);
	c_fail: cover property (take && is_done && tx_frame.result == pds_pkg::RESULT_FAIL);
	c_resend: cover property (take && is_req && wait_ff);
endmodule

bind pds_sequencer pds_checker #(
	.TRANS_WAIT_CYC(TRANS_WAIT_CYC),
	.RSP_TIMEOUT_CYC(RSP_TIMEOUT_CYC)
) chk (
	.mclk, .reset, .start, .peer_to_peer, .data_retained, .speed_usable, .tx_valid,
	.tx_ready, .tx_frame, .rsp_valid, .busy, .error_led
);

//--- test/pds_peer.sv
/* pds_peer: equipment answering download requests.
   assumes: one answer per request; the bench picks flaws. */
`timescale 1ns/1ps
module pds_peer (
	// clock
	input wire logic mclk,
	// frames from the sequencer
	input wire logic tx_valid,
	output logic tx_ready,
	input wire pds_pkg::pds_tx_s tx_frame,
	// answers toward the sequencer
	output logic rsp_valid,
	output pds_pkg::pds_rsp_s rsp_hdr,
	output logic pay_valid,
	input wire logic pay_ready,
	output logic [7:0] pay_data,
	output logic pay_last,
	// behaviour chosen by the bench
	input wire logic [71:0] sw_info,
	input wire logic [15:0] split,
	input wire logic [7:0] env,
	input wire logic [7:0] nbytes,
	input wire logic [2:0] drops,
	input wire logic [1:0] flaw,
	input wire logic slow
);
	pds_pkg::pds_tx_s f; // request being answered
	logic [15:0] seq_ff = 16'hFFFF; // sequence last asked for
	int miss; // answers dropped for this sequence
	// header pulse, then bytes held until taken; flaw 3 spoils fcc
	task automatic answer();
		int n;
		n = (f.seq == pds_pkg::SEQ_INFO || flaw == 2'h3) ? 0 : int'(nbytes);
		rsp_hdr.fcc_ok = flaw != 2'h3;
		rsp_hdr.frame_number = flaw == 2'h1 ? 8'h00 : f.frame_number + {7'h00, flaw[1]};
		rsp_hdr.maker = sw_info[71:48];
		rsp_hdr.data_length = f.seq == pds_pkg::SEQ_INFO ? 16'h000E : 16'(n + 2);
		rsp_hdr.sw_info = sw_info;
		rsp_hdr.split_count = split;
		rsp_valid = 1'b1;
		@(posedge mclk) #1;
		rsp_valid = 1'b0;
		rsp_hdr = ~rsp_hdr; // stale header scrambled
		for (int i = 0; i < n; i++) begin
			pay_valid = 1'b1;
			pay_data = (f.seq == pds_pkg::SEQ_ENV && i == 0) ? env : 8'(i);
			pay_last = i == n - 1;
			@(posedge mclk);
			while (!pay_ready) @(posedge mclk);
			#1;
		end
		pay_valid = 1'b0;
		pay_last = 1'b0;
		pay_data = ~pay_data; // released line shows no stale byte
	endtask
	// answer requests, dropping the first ones when asked
	initial begin
		tx_ready = 1'b1;
		{rsp_valid, pay_valid, pay_last} = 3'b000;
		pay_data = 8'hA5;
		rsp_hdr = '0;
		forever begin
			@(posedge mclk);
			if (tx_valid && tx_ready && tx_frame.kind == pds_pkg::PDS_TX_REQ) begin
				f = tx_frame;
				miss = (f.seq == seq_ff) ? miss : 0;
				seq_ff = f.seq;
				repeat (slow ? 9 : 1) @(posedge mclk);
				#1;
				if (miss < int'(drops)) miss++;
				else answer();
			end
		end
	end
endmodule

//--- test/tb_program_download_sequencer.sv
/* tb_program_download_sequencer: directed scenarios.
   assumes: pds_peer answers; pds_checker is bound. */
`timescale 1ns/1ps
module tb_program_download_sequencer;
	localparam int unsigned TW = 50; // shortened transition wait
	localparam int unsigned TO = 40; // shortened response timeout
	localparam logic [71:0] HELD = 72'h5A5A5A_010203040506; // software held
	localparam logic [71:0] NEWER = 72'h5A5A5A_0102030405FF; // same maker, new program
	logic mclk, reset, start, peer_to_peer, data_retained, speed_usable, prog_ready;
	logic tx_valid, tx_ready, rsp_valid, pay_valid, pay_ready, pay_last, slow, stall;
	logic prog_valid, prog_discard, busy, done_ok, error_led;
	logic [7:0] pay_data, prog_data, env, nbytes, first_body;
	logic [71:0] peer_sw;
	logic [15:0] split;
	logic [2:0] drops;
	logic [1:0] flaw;
	pds_pkg::pds_tx_s tx_frame, last_tx;
	pds_pkg::pds_rsp_s rsp_hdr;
	int fails, samples_checked, n_req, n_prog, n_disc, cyc;
	pds_sequencer #(.TRANS_WAIT_CYC(TW), .RSP_TIMEOUT_CYC(TO)) uut (
		.mclk, .reset, .start, .peer_to_peer, .data_retained, .speed_usable,
		.stored_sw_info(HELD), .own_env_id(pds_pkg::ENV_INTERP), .tx_valid, .tx_ready,
		.tx_frame, .rsp_valid, .rsp_hdr, .pay_valid, .pay_ready, .pay_data, .pay_last,
		.prog_valid, .prog_ready, .prog_data, .prog_discard, .busy, .done_ok, .error_led);
	pds_peer u_peer (.mclk, .tx_valid, .tx_ready, .tx_frame, .rsp_valid, .rsp_hdr,
		.pay_valid, .pay_ready, .pay_data, .pay_last, .sw_info(peer_sw), .split, .env,
		.nbytes, .drops, .flaw, .slow);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// tallies; store stalls in bursts to fill the fifo
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		prog_ready <= #1 !stall || cyc[4];
		if (tx_valid && tx_ready) last_tx <= tx_frame;
		if (tx_valid && tx_ready && tx_frame.kind == pds_pkg::PDS_TX_REQ) n_req <= n_req + 1;
		if (prog_valid && prog_ready && n_prog == 0) first_body <= prog_data;
		if (prog_valid && prog_ready) n_prog <= n_prog + 1;
		if (prog_discard) n_disc <= n_disc + 1;
	end
	task automatic end_sim();
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	task automatic set_peer(input logic [71:0] sw, input logic [15:0] sc, input logic [7:0] ev,
		input logic [7:0] nb, input logic [2:0] dr, input logic [1:0] fl, input logic sl);
		{peer_sw, split, env, nbytes, drops, flaw, slow} = {sw, sc, ev, nb, dr, fl, sl};
	endtask
	// one download, then the store drains
	task automatic run(input logic [7:0] res);
		int k;
		{n_req, n_prog, n_disc} = '0;
		start = 1'b1;
		@(posedge mclk) #1;
		start = 1'b0;
		for (k = 0; k < 60000 && busy !== 1'b0; k++) @(posedge mclk) #1;
		stall = 1'b0;
		for (int j = 0; j < 64 && (prog_valid !== 1'b0 || j < 2); j++) @(posedge mclk) #1;
		check(k < 60000, 1'b1, "hung");
		if (k == 60000) end_sim();
		check(last_tx.kind, pds_pkg::PDS_TX_DONE, "last kind");
		check(last_tx.result, res, "result");
		check(done_ok, res == pds_pkg::RESULT_OK, "ok flag");
		check(error_led, res == pds_pkg::RESULT_FAIL, "err led");
	endtask
	// same software, matching environment, after the transition wait
	task automatic s_skip();
		{peer_to_peer, data_retained, speed_usable} = 3'b111;
		set_peer(HELD, 16'h0004, pds_pkg::ENV_INTERP, 8'h06, 3'h0, 2'h0, 1'b1);
		run(pds_pkg::RESULT_OK);
		check(n_req, 2, "skip reqs");
	endtask
	// new software at current speed with a stalling store
	task automatic s_full();
		{peer_to_peer, data_retained, speed_usable, stall} = 4'b0001;
		set_peer(NEWER, 16'h0003, pds_pkg::ENV_INTERP, 8'h14, 3'h0, 2'h0, 1'b0);
		run(pds_pkg::RESULT_OK);
		check(n_req, 4, "full reqs");
		check(n_prog, 59, "body bytes");
		check(first_body, 8'h01, "first byte");
	endtask
	// three lost answers per sequence
	task automatic s_retry();
		speed_usable = 1'b1;
		set_peer(NEWER, 16'h0002, pds_pkg::ENV_INTERP, 8'h04, 3'h3, 2'h0, 1'b1);
		run(pds_pkg::RESULT_OK);
		check(n_req, 12, "retry reqs");
	endtask
	// zero fn passes; bad fn, check code, silence fail
	task automatic s_flaws();
		logic [1:0] fl[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
		for (int i = 0; i < 4; i++) begin
			set_peer(NEWER, 16'h0002, 8'h00, 8'h04, i == 3 ? 3'h4 : 3'h0, fl[i], 1'b0);
			run(i == 0 ? pds_pkg::RESULT_OK : pds_pkg::RESULT_FAIL);
			check(n_req, i == 0 ? 3 : 4, "flaw reqs");
		end
	endtask
	// reserved environment byte, foreign maker, oversize body
	task automatic s_bad();
		logic [71:0] sw[3] = '{NEWER, 72'h123456_010203040506, NEWER};
		logic [7:0] ev[3] = '{8'h05, 8'h00, 8'h00};
		for (int i = 0; i < 3; i++) begin
			set_peer(sw[i], i == 2 ? 16'h0120 : 16'h0002, ev[i], 8'h80, 3'h0, 2'h0, 1'b0);
			run(pds_pkg::RESULT_FAIL);
			check(n_disc != 0, 1'b1, "discard");
		end
	endtask
	initial begin
		{reset, speed_usable, prog_ready} = 3'b111;
		{start, peer_to_peer, data_retained, stall} = 4'b0000;
		set_peer(HELD, 16'h0002, 8'h00, 8'h04, 3'h0, 2'h0, 1'b0);
		repeat (5) @(posedge mclk);
		#1 reset = 1'b0;
		s_skip();
		s_full();
		s_retry();
		s_flaws();
		s_bad();
		end_sim();
	end
endmodule
